// file: pd_seq_if.sv
// carrier between the register front end and the power-down stepper
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface pd_seq_if;
	logic [6:0][2:0] slots;
	logic            start;
	logic [6:0]      regOnSet;
	logic [6:0]      regEnable;
	logic            busy;
	logic            done;
	modport ctrl (output slots, start, regOnSet, input regEnable, busy, done);
	modport seq  (input slots, start, regOnSet, output regEnable, busy, done);
endinterface

// file: pd_seq_pkg.sv
// constants shared by the power-down slot controller and its stepper
// assumes a 50 MHz clock and word-aligned AHB-Lite register access
package pd_seq_pkg;
	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0] IDX_DEEP_OFF = 8'h5B;
	localparam logic [7:0] IDX_BUCK1    = 8'h5F;
	localparam logic [7:0] IDX_BUCK2    = 8'h60;
	localparam logic [7:0] IDX_BUCK3    = 8'h61;
	localparam logic [7:0] IDX_LINEAR1  = 8'h62;
	localparam logic [7:0] IDX_LINEAR2  = 8'h63;
	localparam logic [7:0] IDX_LINEAR3  = 8'h64;
	localparam logic [7:0] IDX_MEMREF   = 8'h65;
	localparam logic [7:0] IDX_STATUS   = 8'h66;
	// ************************************************************
	// fields and reset values
	// ************************************************************
	localparam int         NUM_OUTPUTS      = 7;
	localparam int         SLOT_W           = 3;
	localparam int         DEEP_OFF_BIT     = 1;
	localparam logic       DEEP_OFF_RESET   = 1'b0;
	localparam logic [2:0] LAST_SLOT        = 3'h7;
	localparam logic [2:0] FIRST_SLOT       = 3'h0;
	localparam int         STAT_BUSY_BIT    = 8;
	localparam int         STAT_DONE_BIT    = 9;
	localparam int         STAT_COREOFF_BIT = 10;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int STEP_TIME_NS  = 2000;
	localparam int STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// stepper states, gray along idle -> step -> done
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_STEP = 2'b01,
		SEQ_DONE = 2'b11
	} seq_state_t;
endpackage

// file: power_down_sequencer_ctrl.sv
// power-down slot registers with an AHB-Lite slave and the deep-off request
// assumes one clock, zero-wait bus, fused slots stable from reset release
//
// Notes on behaviour
// - deep-off bit set while regulators disabled raises the core-off request
// - each of seven outputs owns its own 3-bit power-down slot field
// - after reset each power-down slot loads that output's power-up slot
// - power-down drops outputs from highest slot value down to lowest
// - all slots zero: every output switches off at once, no ordering
// - host may rewrite slots while system on; next sequence uses them
// - power-up order comes only from fuses or test source, never writes
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
module power_down_sequencer_ctrl
	import pd_seq_pkg::*;
#(
	parameter int STEP_COUNT = STEP_CYCLES
) (
	// clock and reset
	input  wire logic            clk,
	input  wire logic            reset_n,
	// ahb-lite slave
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output      logic            hreadyout,
	output      logic [31:0]     hrdata,
	output      logic            hresp,
	// chip state and fused configuration
	input  wire logic            systemOn,
	input  wire logic            regsDisabled,
	input  wire logic            powerDownStart,
	input  wire logic [6:0][2:0] powerUpSlot,
	input  wire logic [6:0]      regOnSet,
	// regulator control and status
	output      logic [6:0]      regEnable,
	output      logic            sequenceBusy,
	output      logic            sequenceDone,
	output      logic            coreOffRequest
);
	typedef struct packed {
		logic            loaded;
		logic            deepOff;
		logic [6:0][2:0] slots;
		logic            wrPend;
		logic [7:0]      wrIdx;
		logic [31:0]     rdata;
		logic            coreOff;
	} ctrl_state_t;

	ctrl_state_t s;
	ctrl_state_t next_s;
	logic        access;
	logic [7:0]  addrIdx;
	logic [31:0] status;
	pd_seq_if    link ();

	// ************************************************************
	// stepper
	// ************************************************************
	power_down_stepper #(
		.STEP_COUNT (STEP_COUNT)
	) stepper (
		.clk     (clk),
		.reset_n (reset_n),
		.bus     (link.seq)
	);

	// a start while a sequence runs is dropped, not queued
	assign link.start    = powerDownStart & ~link.busy;
	assign link.slots    = s.slots;
	assign link.regOnSet = regOnSet;

	// ************************************************************
	// bus and top-level outputs
	// ************************************************************
	assign access         = hsel & htrans[1] & hready;
	assign addrIdx        = haddr[9:2];
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign hrdata         = s.rdata;
	assign regEnable      = link.regEnable;
	assign sequenceBusy   = link.busy;
	assign sequenceDone   = link.done;
	assign coreOffRequest = s.coreOff;

	// status word seen by software
	always_comb begin
		status                   = '0;
		status[6:0]              = link.regEnable;
		status[STAT_BUSY_BIT]    = link.busy;
		status[STAT_DONE_BIT]    = link.done;
		status[STAT_COREOFF_BIT] = s.coreOff;
	end

	// ************************************************************
	// register file
	// ************************************************************
	always_comb begin
		next_s        = s;
		next_s.loaded = 1'b1;
		// fused slots are caught on the first clock after release
		if (!s.loaded) begin
			next_s.slots = powerUpSlot;
		end
		// write data phase; slot writes only land while the system is on
		if (s.wrPend) begin
			if (s.wrIdx == IDX_DEEP_OFF) begin
				next_s.deepOff = hwdata[DEEP_OFF_BIT];
			end
			for (int i = 0; i < NUM_OUTPUTS; i++) begin
				if (s.wrIdx == IDX_BUCK1 + 8'(i) && systemOn && s.loaded) begin
					next_s.slots[i] = hwdata[SLOT_W-1:0];
				end
			end
		end
		next_s.wrPend = access & hwrite;
		next_s.wrIdx  = addrIdx;
		// read data is built from the updated copy so write-then-read sees it
		next_s.rdata = '0;
		if (access && !hwrite) begin
			if (addrIdx == IDX_DEEP_OFF) begin
				next_s.rdata[DEEP_OFF_BIT] = next_s.deepOff;
			end
			if (addrIdx == IDX_STATUS) begin
				next_s.rdata = status;
			end
			for (int i = 0; i < NUM_OUTPUTS; i++) begin
				if (addrIdx == IDX_BUCK1 + 8'(i)) begin
					next_s.rdata[SLOT_W-1:0] = next_s.slots[i];
				end
			end
		end
		// core-off request holds while both conditions hold
		next_s.coreOff = next_s.deepOff & regsDisabled;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '{loaded: 1'b0, deepOff: DEEP_OFF_RESET, slots: '0, wrPend: 1'b0,
				wrIdx: 8'h00, rdata: 32'h0, coreOff: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	core_off_entry_a: assert property (
		s.wrPend && s.wrIdx == IDX_DEEP_OFF && hwdata[DEEP_OFF_BIT] && regsDisabled
		|=> coreOffRequest)
		else $error("deep-off write in disabled state gave no core-off request");
	core_off_clear_a: assert property (
		!s.deepOff |-> !coreOffRequest)
		else $error("core-off request without the deep-off bit");
	slot_reset_load_a: assert property (
		$rose(s.loaded) |-> s.slots == $past(powerUpSlot))
		else $error("power-down slots not loaded from power-up slots");
	slot_write_gate_a: assert property (
		s.loaded && s.wrPend && !systemOn |=> $stable(s.slots))
		else $error("slot written outside the on states");
	slot_change_src_a: assert property (
		$past(s.loaded) && $changed(s.slots) |-> $past(s.wrPend) && $past(systemOn))
		else $error("slots changed without a host write");
	slot_readback_a: assert property (
		access && !hwrite && addrIdx == IDX_BUCK2 && !s.wrPend
		|=> hrdata == {29'h0, $past(s.slots[1])})
		else $error("slot read back wrong");

	on_write_c:  cover property (s.wrPend && systemOn && s.wrIdx == IDX_MEMREF);
	core_off_c:  cover property ($rose(coreOffRequest));
	seq_start_c: cover property (link.start && s.slots != '0);
endmodule

// file: power_down_stepper.sv
// power-down stepper: walks slot values downward and drops regulator enables
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/100ps
module power_down_stepper
	import pd_seq_pkg::*;
#(
	parameter int STEP_COUNT = STEP_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// link to the register front end
	pd_seq_if.seq    bus
);
	localparam int CW = $clog2(STEP_COUNT + 1);
	localparam logic [CW-1:0] CNT_END = CW'(STEP_COUNT - 1);

	typedef struct packed {
		seq_state_t      st;
		logic [2:0]      slot;
		logic [6:0][2:0] snap;
		logic [CW-1:0]   cnt;
		logic [6:0]      en;
	} step_state_t;

	step_state_t s;
	step_state_t next_s;
	logic [6:0]  matchMask;

	// ************************************************************
	// outputs to the front end
	// ************************************************************
	assign bus.regEnable = s.en;
	assign bus.busy      = (s.st == SEQ_STEP);
	assign bus.done      = (s.st == SEQ_DONE);

	// outputs whose slot equals the one being served
	always_comb begin
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			matchMask[i] = (s.snap[i] == s.slot);
		end
	end

	// ************************************************************
	// sequencing
	// ************************************************************
	always_comb begin
		next_s = s;
		case (s.st)
			SEQ_IDLE: begin
				// power-up side may only raise enables while we are not sequencing
				next_s.en = s.en | bus.regOnSet;
				if (bus.start) begin
					// snapshot so a late rewrite cannot tear a running sequence
					next_s.snap = bus.slots;
					if (bus.slots == '0) begin
						next_s.en = '0;
						next_s.st = SEQ_DONE;
					end else begin
						next_s.slot = LAST_SLOT;
						next_s.cnt  = '0;
						next_s.st   = SEQ_STEP;
					end
				end
			end
			SEQ_STEP: begin
				// all outputs sharing this slot drop together at the step start
				if (s.cnt == '0) begin
					next_s.en = s.en & ~matchMask;
				end
				if (s.cnt == CNT_END) begin
					next_s.cnt = '0;
					if (s.slot == FIRST_SLOT) begin
						next_s.st = SEQ_DONE;
					end else begin
						next_s.slot = s.slot - 3'h1;
					end
				end else begin
					next_s.cnt = s.cnt + CW'(1);
				end
			end
			SEQ_DONE: begin
				next_s.st = SEQ_IDLE;
			end
			default: begin
				next_s.st = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '{st: SEQ_IDLE, slot: FIRST_SLOT, snap: '0, cnt: '0, en: '0};
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	all_off_bypass_a: assert property (
		s.st == SEQ_IDLE && bus.start && bus.slots == '0 |=> s.en == '0 && s.st == SEQ_DONE)
		else $error("zero slots did not switch all outputs off at once");
	slot_descends_a: assert property (
		s.st == SEQ_STEP && $past(s.st) == SEQ_STEP |-> s.slot <= $past(s.slot))
		else $error("slot value rose during power-down");
	group_off_a: assert property (
		s.st == SEQ_STEP && s.cnt == '0 |=> (s.en & $past(matchMask)) == '0)
		else $error("output of current slot still enabled");
	step_spacing_a: assert property (
		s.st == SEQ_STEP && $past(s.st) == SEQ_STEP && $changed(s.slot)
		|-> $past(s.cnt) == CNT_END)
		else $error("slot advanced before the step interval ran out");
	seq_ends_off_a: assert property (
		s.st == SEQ_DONE |-> s.en == '0)
		else $error("outputs left on after power-down");

	bypass_c:   cover property (s.st == SEQ_IDLE && bus.start && bus.slots == '0);
	full_seq_c: cover property (s.st == SEQ_STEP ##1 s.st == SEQ_DONE);
endmodule

// file: testbench.sv
// self-checking bench for the power-down slot controller top module
// assumes pd_seq_pkg and the design files are compiled before this file
`timescale 1ns/100ps
module testbench;
	import pd_seq_pkg::*;
	// ************************************************************
	// signals
	// ************************************************************
	localparam int   STEP = 4;
	logic            clk, reset_n, hsel, hwrite, hreadyout, hresp, dRead;
	logic            systemOn, regsDisabled, powerDownStart;
	logic            sequenceBusy, sequenceDone, coreOffRequest;
	logic [31:0]     haddr, hwdata, hrdata;
	logic [1:0]      htrans;
	logic [6:0]      regOnSet, regEnable, lastEn;
	logic [6:0][2:0] powerUpSlot, slots;
	logic [31:0]     rdQ[$];
	logic [6:0]      enQ[$];
	int              fail_count, comparisons;

	// hready is fed back from hreadyout: this slave is alone on the bus
	power_down_sequencer_ctrl #(.STEP_COUNT(STEP)) uut (
		.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .systemOn(systemOn),
		.regsDisabled(regsDisabled), .powerDownStart(powerDownStart),
		.powerUpSlot(powerUpSlot), .regOnSet(regOnSet), .regEnable(regEnable),
		.sequenceBusy(sequenceBusy), .sequenceDone(sequenceDone),
		.coreOffRequest(coreOffRequest));

	// ************************************************************
	// checking and closing
	// ************************************************************
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task end_of_test;
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watcher: read data in each read data phase, every regEnable change
	always @(posedge clk) begin
		if (dRead) begin
			check("hrdata", hrdata, rdQ.size() ? rdQ.pop_front() : 'x);
			check("hresp", 32'(hresp), 32'h0);
		end
		dRead <= hsel && htrans[1] && !hwrite && hreadyout && reset_n;
		if (regEnable !== lastEn) begin
			check("regEnable", 32'(regEnable), enQ.size() ? 32'(enQ.pop_front()) : 'x);
			lastEn = regEnable;
		end
	end

	// ************************************************************
	// bus and sequence tasks
	// ************************************************************
	task bus(logic [7:0] idx, logic wr, logic [31:0] data);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= data;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
	endtask

	task rd(logic [7:0] idx, logic [31:0] exp);
		rdQ.push_back(exp);
		bus(idx, 1'b0, 32'h0);
	endtask

	task read_slots(logic [6:0][2:0] e);
		for (int i = 0; i < 7; i++)
			rd(IDX_BUCK1 + 8'(i), 32'(e[i]));
	endtask

	// upper bits written as ones must read back as zero
	task prog;
		for (int i = 0; i < 7; i++)
			bus(IDX_BUCK1 + 8'(i), 1'b1, 32'hFFFFFFF8 | 32'(slots[i]));
		read_slots(slots);
	endtask

	// power all outputs on, then power down and predict each drop
	task pd_run;
		logic [6:0] cur, nxt;
		int         n;
		enQ.push_back(7'h7F);
		@(posedge clk);
		regOnSet <= 7'h7F;
		@(posedge clk);
		regOnSet <= 7'h00;
		repeat (2) @(posedge clk);
		cur = 7'h7F;
		for (int s = 7; s >= 0; s--) begin
			nxt = cur;
			for (int i = 0; i < 7; i++)
				if (slots[i] == s) nxt[i] = 1'b0;
			if (nxt != cur) enQ.push_back(nxt);
			cur = nxt;
		end
		@(posedge clk);
		powerDownStart <= 1'b1;
		@(posedge clk);
		powerDownStart <= 1'b0;
		#1;
		check("busy", 32'(sequenceBusy), 32'(slots != '0));
		n = 1;
		while (sequenceDone !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("doneEdges", n, slots == '0 ? 1 : 8 * STEP + 1);
		// the watcher sees a drop one edge late, so the bypass drop needs time
		repeat (2) @(posedge clk);
		check("dropsLeft", enQ.size(), 0);
	endtask

	// ************************************************************
	// clock, watchdog and main sequence
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test;
	end

	initial begin
		void'($urandom(98295));
		{reset_n, hsel, hwrite, powerDownStart, regsDisabled, dRead} = '0;
		systemOn = 1'b1;
		{haddr, hwdata, htrans, regOnSet, lastEn} = '0;
		powerUpSlot = 21'($urandom);
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		read_slots(powerUpSlot);
		rd(IDX_DEEP_OFF, 32'h0);
		rd(8'h70, 32'h0);
		slots = powerUpSlot;
		pd_run;
		repeat (3) begin
			slots = 21'($urandom);
			prog;
			pd_run;
		end
		// slot writes are dropped while the system is off
		systemOn <= 1'b0;
		bus(IDX_BUCK1, 1'b1, 32'(~slots[0]));
		systemOn <= 1'b1;
		rd(IDX_BUCK1, 32'(slots[0]));
		slots = '0;
		prog;
		pd_run;
		// deep-off request acts only in the regulators-disabled state
		regsDisabled <= 1'b1;
		bus(IDX_DEEP_OFF, 1'b1, 32'hFFFFFFFF);
		rd(IDX_DEEP_OFF, 32'h2);
		rd(IDX_STATUS, 32'h400);
		check("coreOff", 32'(coreOffRequest), 32'h1);
		regsDisabled <= 1'b0;
		repeat (2) @(posedge clk);
		rd(IDX_STATUS, 32'h0);
		check("coreOffClr", 32'(coreOffRequest), 32'h0);
		bus(IDX_DEEP_OFF, 1'b1, 32'h0);
		// a second reset reloads the fused order, never the written one
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		read_slots(powerUpSlot);
		end_of_test;
	end
endmodule
